// ==== aos_defines.svh ====
// offsets, reset values and timing figures of the auxiliary output sequencer
`ifndef AOS_DEFINES_SVH
`define AOS_DEFINES_SVH

// ==========================================
// register offsets
`define AOS_OFS_A_DELAY 8'h10
`define AOS_OFS_B_DELAY 8'h11
`define AOS_OFS_CONTROL 8'h12
`define AOS_OFS_CONFIG  8'h13

// ==========================================
// reset values
`define AOS_RST_A_DELAY 8'h07
`define AOS_RST_B_DELAY 8'h0A
`define AOS_RST_CONTROL 8'h77
`define AOS_RST_CONFIG  8'h06

// ==========================================
// writable bits of the control register
`define AOS_CONTROL_WMASK 8'h77

// ==========================================
// timing
`define AOS_CLK_PERIOD_NS 10
`define AOS_HALF_STEP_NS  500000

`endif

// ==== aos_pkg.sv ====
// types of the auxiliary output sequencer
package aos_pkg;

	// ==========================================
	// delay register: fall code high, rise code low
	typedef struct packed {
		logic [3:0] fallCode;
		logic [3:0] riseCode;
	} aos_delay_t;

	// ==========================================
	// output control register
	typedef struct packed {
		logic reserved7;
		logic auxBOpenDrain;
		logic auxBFollowPin;
		logic auxBLevel;
		logic reserved3;
		logic auxAOpenDrain;
		logic auxAFollowPin;
		logic auxALevel;
	} aos_ctrl_t;

	// ==========================================
	// sequencing configuration register
	typedef struct packed {
		logic reserved7;
		logic riseRangeSel;
		logic fallRangeSel;
		logic sharedPinFunction;
		logic sharedPinPulldown;
		logic enablePinPulldown;
		logic thermalWarnThreshold;
		logic spreadSpectrumOn;
	} aos_cfg_t;

endpackage : aos_pkg

// ==== aos_aux_output_sequencer.sv ====
// auxiliary output sequencer: two delayed general purpose outputs
// Functional notes
// R01 - a falls after the enable pin falls, delayed by its fall code at 0.5 ms per step.
// R02 - a rises after the enable pin rises, delayed by its rise code, code 0 meaning none.
// R03 - b falls after the enable pin falls, delayed by its own fall code on the same scale.
// R04 - b rises after the enable pin rises, delayed by its own rise code, reset 0xA.
// R05 - the rise range bit picks 0.5 ms steps when 0 and 1 ms steps when 1.
// R06 - the fall range bit scales all fall codes the same way.
// R07 - b follows its level bit alone, or level bit and delayed enable when pin-controlled.
// R08 - a follows its level bit alone, or level bit and delayed enable when pin-controlled.
// R09 - b level bit sets low or high, only while the shared pin is an output.
// R10 - a level bit sets low or high and resets to high.
// R11 - each output type bit picks push-pull at 0 and open-drain at 1, reset open-drain.
// R12 - the pin function bit makes the shared pin output b at 0 or clock input at 1.
// R13 - a config bit enables the shared pin pull-down, also while it is output b.
// R14 - a config bit enables the enable pin pull-down, reset enabled.
// R15 - a config bit picks the thermal warning at 125 C when 0 or 137 C when 1, reset 1.
// R16 - a config bit enables spread spectrum when 1, reset off.
// R17 - in-between codes delay by code times step, counted in half-step units of the clock.
`timescale 1ns/1ns
`include "aos_defines.svh"

module aos_aux_output_sequencer #(
	parameter int HALF_STEP_CYCLES = `AOS_HALF_STEP_NS / `AOS_CLK_PERIOD_NS
) (
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic       enablePin,
	input  wire logic       regWrite,
	input  wire logic [7:0] regAddr,
	input  wire logic [7:0] regWdata,
	output logic      [7:0] regRdata,
	output logic            auxAOut,
	output logic            auxAOe,
	output logic            auxBOut,
	output logic            auxBOe,
	output logic            sharedPinIsClock,
	output logic            sharedPinPulldown,
	output logic            enablePinPulldown,
	output logic            thermalWarnThreshold,
	output logic            spreadSpectrumOn
);

	localparam int PW = (HALF_STEP_CYCLES > 1) ? $clog2(HALF_STEP_CYCLES) : 1;
	localparam logic [PW-1:0] PRESC_LAST = PW'(HALF_STEP_CYCLES - 1);

	// ==========================================
	// elaboration check
	generate
		if (HALF_STEP_CYCLES < 2) begin : gBadParam
			$error("HALF_STEP_CYCLES must be at least 2");
		end
	endgenerate

	// ==========================================
	// enable pin synchroniser
	logic enMeta;
	logic enSync;
	logic enPrev;
	logic next_enMeta;
	logic next_enSync;
	logic next_enPrev;

	always_comb begin
		next_enMeta = enablePin;
		next_enSync = enMeta;
		next_enPrev = enSync;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			enMeta <= 1'b0;
			enSync <= 1'b0;
			enPrev <= 1'b0;
		end else begin
			enMeta <= next_enMeta;
			enSync <= next_enSync;
			enPrev <= next_enPrev;
		end
	end

	// ==========================================
	// register file
	aos_pkg::aos_delay_t aDelay;
	aos_pkg::aos_delay_t bDelay;
	aos_pkg::aos_ctrl_t  ctrl;
	aos_pkg::aos_cfg_t   cfg;
	aos_pkg::aos_delay_t next_aDelay;
	aos_pkg::aos_delay_t next_bDelay;
	aos_pkg::aos_ctrl_t  next_ctrl;
	aos_pkg::aos_cfg_t   next_cfg;
	logic [7:0]          next_regRdata;

	always_comb begin
		next_aDelay   = aDelay;
		next_bDelay   = bDelay;
		next_ctrl     = ctrl;
		next_cfg      = cfg;
		next_regRdata = 8'h00;
		if (regWrite) begin
			case (regAddr)
				`AOS_OFS_A_DELAY: next_aDelay = regWdata;
				`AOS_OFS_B_DELAY: next_bDelay = regWdata;
				// reserved control bits are read-only zero
				`AOS_OFS_CONTROL: next_ctrl = regWdata & `AOS_CONTROL_WMASK;
				`AOS_OFS_CONFIG:  next_cfg = regWdata;
				default: ;
			endcase
		end
		case (regAddr)
			`AOS_OFS_A_DELAY: next_regRdata = aDelay;
			`AOS_OFS_B_DELAY: next_regRdata = bDelay;
			`AOS_OFS_CONTROL: next_regRdata = ctrl;
			`AOS_OFS_CONFIG:  next_regRdata = cfg;
			default:          next_regRdata = 8'h00;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			aDelay   <= `AOS_RST_A_DELAY;
			bDelay   <= `AOS_RST_B_DELAY; // R04
			ctrl     <= `AOS_RST_CONTROL; // R10 R11
			cfg      <= `AOS_RST_CONFIG;  // R14 R15 R16
			regRdata <= 8'h00;
		end else begin
			aDelay   <= next_aDelay;
			bDelay   <= next_bDelay;
			ctrl     <= next_ctrl;
			cfg      <= next_cfg;
			regRdata <= next_regRdata;
		end
	end

	// ==========================================
	// per-output delay of the enable level
	logic [1:0][3:0]    riseCode;
	logic [1:0][3:0]    fallCode;
	logic [1:0][4:0]    remain;
	logic [1:0][PW-1:0] presc;
	logic [1:0]         delayedEn;

	assign riseCode[0] = aDelay.riseCode;
	assign riseCode[1] = bDelay.riseCode;
	assign fallCode[0] = aDelay.fallCode;
	assign fallCode[1] = bDelay.fallCode;

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : gChan
			logic [4:0]    loadHalves;
			logic [4:0]    next_remain;
			logic [PW-1:0] next_presc;
			logic          next_delayedEn;

			always_comb begin
				// range bit doubles the half-step count
				if (enSync) begin
					loadHalves = {1'b0, riseCode[ch]} << cfg.riseRangeSel; // R02 R04 R05
				end else begin
					loadHalves = {1'b0, fallCode[ch]} << cfg.fallRangeSel; // R01 R03 R06
				end
				next_remain    = remain[ch];
				next_presc     = presc[ch];
				next_delayedEn = delayedEn[ch];
				// a new edge restarts the wait, so an enable glitch shorter than the delay is filtered out
				if (enSync != enPrev) begin
					next_presc = '0;
					if (loadHalves == 5'h00) begin
						next_remain    = 5'h00;
						next_delayedEn = enSync; // R01 R02 R03 R04
					end else begin
						next_remain = loadHalves; // R17
					end
				end else if (remain[ch] != 5'h00) begin
					if (presc[ch] == PRESC_LAST) begin
						next_presc  = '0;
						next_remain = remain[ch] - 5'h01; // R17
						if (remain[ch] == 5'h01) begin
							next_delayedEn = enSync; // R17
						end
					end else begin
						next_presc = presc[ch] + PW'(1);
					end
				end
			end

			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					remain[ch]    <= 5'h00;
					presc[ch]     <= '0;
					delayedEn[ch] <= 1'b0;
				end else begin
					remain[ch]    <= next_remain;
					presc[ch]     <= next_presc;
					delayedEn[ch] <= next_delayedEn;
				end
			end
		end
	endgenerate

	// ==========================================
	// pin drivers
	logic aHigh;
	logic bHigh;
	logic next_auxAOut;
	logic next_auxAOe;
	logic next_auxBOut;
	logic next_auxBOe;

	always_comb begin
		aHigh = ctrl.auxALevel & (~ctrl.auxAFollowPin | delayedEn[0]); // R08 R10
		bHigh = ctrl.auxBLevel & (~ctrl.auxBFollowPin | delayedEn[1]); // R07 R09
		// open drain only pulls low; high is left to the external pull-up
		next_auxAOut = aHigh & ~ctrl.auxAOpenDrain; // R11
		next_auxAOe  = ~(aHigh & ctrl.auxAOpenDrain); // R11
		next_auxBOut = bHigh & ~ctrl.auxBOpenDrain; // R11
		next_auxBOe  = ~(bHigh & ctrl.auxBOpenDrain); // R11
		if (cfg.sharedPinFunction) begin
			next_auxBOut = 1'b0; // R12
			next_auxBOe  = 1'b0; // R09 R12
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			auxAOut <= 1'b0;
			auxAOe  <= 1'b0;
			auxBOut <= 1'b0;
			auxBOe  <= 1'b0;
		end else begin
			auxAOut <= next_auxAOut;
			auxAOe  <= next_auxAOe;
			auxBOut <= next_auxBOut;
			auxBOe  <= next_auxBOe;
		end
	end

	// ==========================================
	// configuration outputs, straight from the register
	assign sharedPinIsClock     = cfg.sharedPinFunction;    // R12
	assign sharedPinPulldown    = cfg.sharedPinPulldown;    // R13
	assign enablePinPulldown    = cfg.enablePinPulldown;    // R14
	assign thermalWarnThreshold = cfg.thermalWarnThreshold; // R15
	assign spreadSpectrumOn     = cfg.spreadSpectrumOn;     // R16

	// ==========================================
	// assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	sequence enRise;
		enSync && !enPrev;
	endsequence

	sequence enFall;
		!enSync && enPrev;
	endsequence

	AST_A_ZERO_FALL: assert property (enFall ##0 aDelay.fallCode == 4'h0 |=> !delayedEn[0]) // R01
		else $error("a not low right after fall with zero code");

	AST_A_RISE_WAIT: assert property (enRise ##0 aDelay.riseCode != 4'h0 ##0 !delayedEn[0]
		|=> !delayedEn[0]) // R02
		else $error("a rose before its rise delay");

	AST_B_FALL_WAIT: assert property (enFall ##0 bDelay.fallCode != 4'h0 ##0 delayedEn[1]
		|=> delayedEn[1]) // R03
		else $error("b fell before its fall delay");

	AST_B_ZERO_RISE: assert property (enRise ##0 bDelay.riseCode == 4'h0 |=> delayedEn[1]) // R04
		else $error("b not high right after rise with zero code");

	AST_RISE_SCALE: assert property (enRise |=>
		remain[0] == ({1'b0, $past(aDelay.riseCode)} << $past(cfg.riseRangeSel))) // R05
		else $error("rise delay not scaled by range bit");

	AST_FALL_SCALE: assert property (enFall |=>
		remain[1] == ({1'b0, $past(bDelay.fallCode)} << $past(cfg.fallRangeSel))) // R06
		else $error("fall delay not scaled by range bit");

	AST_STEP_COUNT: assert property (remain[0] != 5'h00 && presc[0] == PRESC_LAST
		&& enSync == enPrev |=> remain[0] == $past(remain[0]) - 5'h01) // R17
		else $error("half step not counted");

	AST_A_LOW: assert property (!ctrl.auxALevel || (ctrl.auxAFollowPin && !delayedEn[0])
		|=> auxAOe && !auxAOut) // R08
		else $error("a not driven low");

	AST_A_FREE: assert property (ctrl.auxALevel && !ctrl.auxAFollowPin
		|=> !(auxAOe && !auxAOut)) // R10
		else $error("a not high with level bit set");

	AST_OPEN_DRAIN: assert property (ctrl.auxAOpenDrain |=> !auxAOut) // R11
		else $error("open drain output driven high");

	AST_SHARED_CLOCK: assert property (cfg.sharedPinFunction |=> !auxBOe) // R12
		else $error("shared pin driven while clock input");

	AST_B_FOLLOW: assert property (!cfg.sharedPinFunction && ctrl.auxBLevel && ctrl.auxBFollowPin
		&& delayedEn[1] && !ctrl.auxBOpenDrain |=> auxBOe && auxBOut) // R07
		else $error("b not high with level and delayed enable");

endmodule : aos_aux_output_sequencer

// ==== aos_host_model.sv ====
// host-side model driving the enable pin and the register port
`timescale 1ns/1ns

module aos_host_model (
	input  wire logic       clk,
	output logic            enablePin,
	output logic            regWrite,
	output logic      [7:0] regAddr,
	output logic      [7:0] regWdata
);
	// ==========================================
	// drive tasks: callers enter just after a rising edge
	initial begin
		enablePin = 1'b0;
		regWrite  = 1'b0;
		regAddr   = 8'h00;
		regWdata  = 8'h00;
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		regAddr  = a;
		regWdata = d;
		regWrite = 1'b1;
		@(posedge clk);
		#1 regWrite = 1'b0;
		// released data shows junk, not the last byte
		regWdata = ~d;
		// one idle edge, so a following write never re-raises the strobe in this step
		@(posedge clk);
		#1;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		regAddr = a;
	endtask : rd

	task automatic setEn(input logic v);
		enablePin = v;
	endtask : setEn
endmodule : aos_host_model

// ==== tb_aux_output_sequencer.sv ====
// self-checking bench of the auxiliary output sequencer
`timescale 1ns/1ns
`define CHK(o, e) begin testsRun++; if ((o) !== (e)) begin errorCnt++; $display("BAD t=%0t got=%h exp=%h", $time, o, e); end end

module tb_aux_output_sequencer;
	// short half step keeps the 15 ms delays cheap
	localparam int H = 4;
	logic        clk, arst_n, enablePin, regWrite, auxAOut, auxAOe, auxBOut, auxBOe;
	logic [7:0]  regAddr, regWdata, regRdata;
	wire  [4:0]  cfgOut;
	logic [7:0]  m [0:3];
	logic [7:0]  r [0:4];
	logic [17:0] expA[$], expB[$], expR[$], e;
	logic [1:0]  pA, pB;
	logic        look, mon, den;
	int          cyc, errorCnt, testsRun, seed;

	aos_aux_output_sequencer #(.HALF_STEP_CYCLES(H)) dut (.clk(clk), .arst_n(arst_n),
		.enablePin(enablePin), .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata),
		.regRdata(regRdata), .auxAOut(auxAOut), .auxAOe(auxAOe), .auxBOut(auxBOut),
		.auxBOe(auxBOe), .sharedPinIsClock(cfgOut[4]), .sharedPinPulldown(cfgOut[3]),
		.enablePinPulldown(cfgOut[2]), .thermalWarnThreshold(cfgOut[1]),
		.spreadSpectrumOn(cfgOut[0]));
	aos_host_model host (.clk(clk), .enablePin(enablePin), .regWrite(regWrite),
		.regAddr(regAddr), .regWdata(regWdata));

	// ==========================================
	// reference model of the pin states {out, oe}
	function automatic logic [1:0] drv(input logic l, input logic od);
		return od ? {1'b0, ~l} : {l, 1'b1};
	endfunction : drv
	function automatic logic [1:0] stA(input logic d);
		return drv(m[2][0] & (d | ~m[2][1]), m[2][2]);
	endfunction : stA
	function automatic logic [1:0] stB(input logic d);
		return m[3][4] ? 2'b00 : drv(m[2][4] & (d | ~m[2][5]), m[2][6]);
	endfunction : stB
	task automatic note(input logic [1:0] oa, input logic [1:0] ob, input int ka, input int kb);
		// absolute cycle, so back-to-back tasks cannot skew a pending note
		if (stA(den) !== oa) expA.push_back({16'(cyc + ka), stA(den)});
		if (stB(den) !== ob) expB.push_back({16'(cyc + kb), stB(den)});
	endtask : note

	// ==========================================
	// stimulus tasks
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [1:0] oa, ob;
		oa = stA(den);
		ob = stB(den);
		if (a < 8'h14) m[a[1:0]] = (a == 8'h12) ? (d & 8'h77) : d;
		note(oa, ob, 2, 2);
		host.wr(a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		expR.push_back({2'b00, ((a < 8'h14) ? m[a[1:0]] : 8'h00), 3'b000, m[3][4:0]});
		host.rd(a);
		@(posedge clk);
		#1 look = 1'b1;
		@(posedge clk);
		#1 look = 1'b0;
	endtask : rd
	task automatic tog(input logic v);
		logic [1:0] oa, ob;
		int         sc;
		oa = stA(den);
		ob = stB(den);
		den = v;
		sc = H * ((v ? m[3][6] : m[3][5]) ? 2 : 1);
		note(oa, ob, 4 + sc * (v ? m[0][3:0] : m[0][7:4]), 4 + sc * (v ? m[1][3:0] : m[1][7:4]));
		host.setEn(v);
		// longest wait is 4 + 15 * 2 * H cycles
		repeat (130) @(posedge clk);
		#1;
	endtask : tog
	task automatic summarize;
		`CHK(expA.size() + expB.size() + expR.size(), 0)
		if (errorCnt == 0 && testsRun > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : summarize

	// ==========================================
	// observers
	always @(posedge clk) cyc <= cyc + 1;
	always @(negedge clk) begin
		if (look) begin
			e = expR.pop_front();
			`CHK({2'b00, regRdata, 3'b000, cfgOut}, e)
		end
		if (mon && {auxAOut, auxAOe} !== pA) begin
			pA = {auxAOut, auxAOe};
			e = expA.size() ? expA.pop_front() : 'x;
			`CHK({cyc[15:0], pA}, e)
		end
		if (mon && {auxBOut, auxBOe} !== pB) begin
			pB = {auxBOut, auxBOe};
			e = expB.size() ? expB.pop_front() : 'x;
			`CHK({cyc[15:0], pB}, e)
		end
	end

	// ==========================================
	// clock, watchdog, main sequence
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		repeat (10000) @(posedge clk);
		errorCnt++;
		summarize();
	end
	initial begin
		seed = 32'h7971B505;
		arst_n = 1'b0;
		look = 1'b0;
		mon = 1'b0;
		den = 1'b0;
		cyc = 0;
		errorCnt = 0;
		testsRun = 0;
		m[0] = 8'h07;
		m[1] = 8'h0A;
		m[2] = 8'h77;
		m[3] = 8'h06;
		repeat (4) @(posedge clk);
		#1 arst_n = 1'b1;
		repeat (3) @(posedge clk);
		#1 pA = stA(1'b0);
		pB = stB(1'b0);
		mon = 1'b1;
		for (int a = 16; a < 21; a++) rd(a[7:0]);
		for (int i = 0; i < 10; i++) begin
			for (int k = 0; k < 5; k++) r[k] = 8'($random(seed));
			// first two passes pin the code endpoints in both ranges
			if (i < 2) begin
				r[0] = i ? 8'h00 : 8'h60;
				r[1] = i ? 8'h0F : 8'hF0;
				r[2] = ~r[1];
				r[3] = 8'h33;
			end
			wr(8'h13, r[0]);
			wr(8'h10, r[1]);
			wr(8'h11, r[2]);
			wr(8'h12, i[0] ? (r[3] | 8'h22) : r[3]);
			wr(8'h14, r[4]);
			for (int a = 16; a < 21; a++) rd(a[7:0]);
			tog(1'b1);
			tog(1'b0);
		end
		summarize();
	end
endmodule : tb_aux_output_sequencer
